//--- src/smsp_defines.svh
// Constants for the serial management slave port
`ifndef SMSP_DEFINES_SVH
`define SMSP_DEFINES_SVH
`define SMSP_START_RD 4'h6
`define SMSP_START_WR 4'h5
`define SMSP_ADDR_W 5
`define SMSP_DATA_W 16
`define SMSP_STRAP_W 3
`define SMSP_ADDR_HI 2'h0
`define SMSP_HDR_BITS 5'h0A
`define SMSP_TA_BITS 5'h02
`define SMSP_DATA_BITS 5'h10
`define SMSP_IDLE_BITS 5'h02
`define SMSP_SETTLE_LAST 2'h3
`endif

//--- src/smsp_pkg.sv
// Types for the serial management slave port
package smsp_pkg;
  typedef enum logic [2:0]
  {
    SMSP_HUNT = 3'h0,
    SMSP_HDR = 3'h1,
    SMSP_TA = 3'h3,
    SMSP_DATA = 3'h2,
    SMSP_TAIL = 3'h6
  } smsp_state_e;
endpackage

//--- src/smsp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module smsp_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

//--- src/smsp_slave.sv
// Serial management slave port, sampled on system clock
// Overview of operation
// - Strap pins give low address bits
// - Upper two address bits must be zero
// - Register address field selects target register
// - Read: host drives 14 bits, device answers
// - No preamble; hunt for 0110 or 0101
`timescale 1ns/1ps
`include "smsp_defines.svh"
module smsp_slave (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mgmt_clk,
  input wire logic mgmt_data_i,
  input wire logic [`SMSP_STRAP_W-1:0] carrier_sense_strap_pins,
  input wire logic [`SMSP_DATA_W-1:0] reg_rdata,
  output logic mgmt_data_o,
  output logic mgmt_data_oe,
  output logic [`SMSP_ADDR_W-1:0] reg_addr,
  output logic [`SMSP_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [`SMSP_ADDR_W-1:0] phy_addr
);
  // ==========================================
  // Input synchronisation
  logic [1:0] sync_out;
  logic [`SMSP_STRAP_W-1:0] strap_s;
  smsp_sync #(.W(2)) u_sync_link (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din({mgmt_clk, mgmt_data_i}),
    .dout(sync_out)
  );
  smsp_sync #(.W(`SMSP_STRAP_W)) u_sync_strap (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(carrier_sense_strap_pins),
    .dout(strap_s)
  );
  logic mdc_s;
  logic mdi_s;
  logic mdc_prev_q;
  logic rise;
  logic fall;
  assign mdc_s = sync_out[1];
  assign mdi_s = sync_out[0];
  assign rise = mdc_s & ~mdc_prev_q;
  assign fall = ~mdc_s & mdc_prev_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mdc_prev_q <= 1'b0;
    else
      mdc_prev_q <= mdc_s;
  end
  // ==========================================
  // Strap capture while reset settles
  logic strap_done_q;
  logic [1:0] settle_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      phy_addr <= '0;
    end
    else if (!strap_done_q)
    begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == `SMSP_SETTLE_LAST)
      begin
        strap_done_q <= 1'b1;
        phy_addr <= {`SMSP_ADDR_HI, strap_s};
      end
    end
  end
  // ==========================================
  // Frame state machine
  smsp_pkg::smsp_state_e state_q;
  logic [3:0] hunt_q;
  logic [4:0] cnt_q;
  logic is_rd_q;
  logic [9:0] hdr_q;
  logic [`SMSP_DATA_W-1:0] sh_q;
  logic [3:0] hunt_d;
  logic hdr_last;
  logic match;
  assign hunt_d = {hunt_q[2:0], mdi_s};
  assign hdr_last = cnt_q == `SMSP_HDR_BITS - 5'h1;
  // Header fully shifted in by the data phase: address sits in the top five bits
  assign match = hdr_q[9:5] == phy_addr;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= smsp_pkg::SMSP_HUNT;
      hunt_q <= 4'h0;
      cnt_q <= 5'h0;
      is_rd_q <= 1'b0;
      hdr_q <= 10'h000;
      reg_addr <= '0;
      reg_wdata <= '0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
    else
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (rise && strap_done_q)
      begin
        unique case (state_q)
          smsp_pkg::SMSP_HUNT:
          begin
            hunt_q <= hunt_d;
            cnt_q <= 5'h0;
            if (hunt_d == `SMSP_START_RD || hunt_d == `SMSP_START_WR)
            begin
              state_q <= smsp_pkg::SMSP_HDR;
              is_rd_q <= hunt_d == `SMSP_START_RD;
              hunt_q <= 4'h0;
            end
          end
          smsp_pkg::SMSP_HDR:
          begin
            hdr_q <= {hdr_q[8:0], mdi_s};
            cnt_q <= cnt_q + 5'h1;
            if (hdr_last)
            begin
              state_q <= smsp_pkg::SMSP_TA;
              cnt_q <= 5'h0;
              reg_addr <= {hdr_q[3:0], mdi_s};
              if (is_rd_q && hdr_q[8:4] == phy_addr)
                reg_rd <= 1'b1;
            end
          end
          smsp_pkg::SMSP_TA:
          begin
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == `SMSP_TA_BITS - 5'h1)
            begin
              state_q <= smsp_pkg::SMSP_DATA;
              cnt_q <= 5'h0;
            end
          end
          smsp_pkg::SMSP_DATA:
          begin
            reg_wdata <= {reg_wdata[`SMSP_DATA_W-2:0], mdi_s};
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == `SMSP_DATA_BITS - 5'h1)
            begin
              state_q <= smsp_pkg::SMSP_TAIL;
              cnt_q <= 5'h0;
              if (!is_rd_q && match)
                reg_wr <= 1'b1;
            end
          end
          smsp_pkg::SMSP_TAIL:
          begin
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == `SMSP_IDLE_BITS - 5'h1)
            begin
              state_q <= smsp_pkg::SMSP_HUNT;
              cnt_q <= 5'h0;
            end
          end
          default:
            state_q <= smsp_pkg::SMSP_HUNT;
        endcase
      end
    end
  end
  // ==========================================
  // Read data drive, changed after falling edge
  logic rd_match_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_match_q <= 1'b0;
      sh_q <= '0;
      mgmt_data_o <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end
    else
    begin
      if (reg_rd)
      begin
        rd_match_q <= 1'b1;
        sh_q <= reg_rdata;
      end
      if (fall)
      begin
        if (rd_match_q && state_q == smsp_pkg::SMSP_TA && cnt_q == `SMSP_TA_BITS - 5'h1)
        begin
          // Second turnaround bit is driven low; data follows from the next fall
          mgmt_data_oe <= 1'b1;
          mgmt_data_o <= 1'b0;
        end
        else if (rd_match_q && state_q == smsp_pkg::SMSP_DATA)
        begin
          mgmt_data_o <= sh_q[`SMSP_DATA_W-1];
          sh_q <= {sh_q[`SMSP_DATA_W-2:0], 1'b0};
        end
        else if (state_q != smsp_pkg::SMSP_TA)
        begin
          mgmt_data_oe <= 1'b0;
          mgmt_data_o <= 1'b0;
          rd_match_q <= 1'b0;
        end
      end
    end
  end
endmodule

//--- test/smsp_slave_chk.sv
// Slave port checker
`timescale 1ns/1ps
module smsp_slave_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] carrier_sense_strap_pins,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic mgmt_data_oe,
  input wire logic [4:0] reg_addr,
  input wire logic [4:0] phy_addr
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  a_strap_low: assert property (reg_rd |-> phy_addr[2:0] == carrier_sense_strap_pins) else $error("strap");
  a_high_zero: assert property (phy_addr[4:3] == 2'h0) else $error("high");
  a_addr_held: assert property (reg_wr |-> $stable(reg_addr)) else $error("addr");
  a_read_drive: assert property ($rose(reg_rd) |-> ##[8:40] mgmt_data_oe) else $error("drive");
  a_drive_quiet: assert property (mgmt_data_oe |-> !reg_wr) else $error("quiet");
  a_drive_hold: assert property ($rose(mgmt_data_oe) |-> mgmt_data_oe [*8]) else $error("hold");
  c_wr: cover property (reg_wr);
  c_rd: cover property (reg_rd);
  c_oe: cover property (mgmt_data_oe);
endmodule
bind smsp_slave smsp_slave_chk chk (.*);

//--- test/smsp_host_model.sv
// Host model
`timescale 1ns/1ps
module smsp_host_model (
  output logic mgmt_clk,
  output logic mgmt_data_i,
  input wire logic mgmt_data_o,
  input wire logic mgmt_data_oe
);
  logic host_o;
  logic host_oe = 1'b0;
  // Released line is pulled high
  assign mgmt_data_i = mgmt_data_oe ? mgmt_data_o : host_oe ? host_o : 1'b1;
  initial mgmt_clk = 1'b0;
  task automatic xfer(input logic [31:0] f, input int pre, output logic [15:0] rd);
    for (int i = -pre; i < 34; i++)
    begin
      host_oe = i < 32 && (!f[29] || i < 14);
      host_o = i < 0 || f[(31 - i) & 31];
      #160 mgmt_clk = 1'b1;
      #150 rd = i > 15 && i < 32 ? {rd[14:0], mgmt_data_i} : rd;
      #10 mgmt_clk = 1'b0;
    end
  endtask
endmodule

//--- test/smsp_slave_test.sv
// Slave port testbench
`timescale 1ns/1ps
module smsp_slave_test;
  logic sys_clk = 1'b0, sys_rst = 1'b1;
  logic mgmt_clk, mgmt_data_i, mgmt_data_o, mgmt_data_oe, reg_wr, reg_rd;
  logic [4:0] reg_addr, phy_addr;
  logic [15:0] reg_wdata, rd;
  int mismatches = 0, n_tests = 0, n_st = 0, cyc = 0;
  logic [2:0] strap = 3'h5;
  wire [15:0] reg_rdata = {reg_addr, 6'h2A, reg_addr};
  smsp_slave DUT (.*, .carrier_sense_strap_pins(strap));
  smsp_host_model host (.*);
  always #20 sys_clk = ~sys_clk;
  // Strobes are counted on the falling edge, where they are settled
  always @(negedge sys_clk)
  begin
    n_st += reg_wr + reg_rd;
    if (++cyc == 4000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    mismatches += got !== exp;
    if (got !== exp) $display("Error %0t %h %h", $time, got, exp);
  endtask
  task automatic frame(input logic [31:0] f, input int pre, input int nst);
    n_st = 0;
    @(posedge sys_clk);
    #1 host.xfer(f, pre, rd);
    chk(16'(n_st), 16'(nst));
  endtask
  task t_write;
    frame({4'h5, 10'h0BF, 18'h2_A5C3}, 0, 1);
    chk(reg_wdata, 16'hA5C3);
    chk(16'(reg_addr), 16'h001F);
    $display("write done");
  endtask
  task t_read;
    frame({4'h6, 10'h0AA, 18'h0_0000}, 32, 1);
    chk(rd, 16'h554A);
    $display("read done");
  endtask
  task t_foreign;
    frame({4'h6, 10'h1A1, 18'h0_0000}, 0, 0);
    chk(rd, 16'hFFFF);
    $display("foreign done");
  endtask
  task t_restrap;
    strap = 3'h2;
    @(posedge sys_clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(16'(phy_addr), 16'h0002);
    frame({4'h5, 5'h02, 5'h03, 2'h2, 16'h3C5A}, 0, 1);
    chk(reg_wdata, 16'h3C5A);
    chk(16'(reg_addr), 16'h0003);
    frame({4'h5, 10'h0BF, 18'h2_0000}, 0, 0);
    $display("restrap done");
  endtask
  task end_sim;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(16'(phy_addr), 16'h0005);
    t_write;
    t_read;
    t_foreign;
    t_restrap;
    end_sim();
  end
endmodule
